/* File: regbank_map.svh */
// Behaviour
// - First status bit 6 reads 1 when horizontal loop unlocked.
// - First status bit 5 reads 1 while slow time constant active.
// - First status bits 4 and 3 flag luma gain at top/bottom limit.
// - First status bit 2 reads 1 while white peak loop active.
// - First status bits 1:0 give colour standard: BW, NTSC, PAL, SECAM.
// - First status register read-only, bits 6:0 defined; writes ignored.
// - Second status register read-only; bits 7:5, 3:0 defined, bit 4 none.
// - Second status bit 7 reads 1 for interlaced video.
// - Second status bit 6 reads 0 only when both loops locked.
// - Second status bit 5 is 0 for 50 Hz, 1 for 60 Hz.
// - Second status bit 3 flags four-line type 3 stripe burst.
// - Second status bit 2 flags a stripe burst of any type.
// - Second status bit 1 flags a copy-protected source.
// - Second status bit 0 reads 1 only when all loops locked.
// - Control bit 6 drives the AD port when 1, releases it when 0.
// - Control bit 5 selects ADC clock: line-locked or external pin.
// - Control bit 4: clamp follows clamp setting, or reference mode.
// - Control bit 2 lets source-switch pin edges reset gain loop.
// - Gain A is 9 bits: msb control bit 0, low byte at 24H.
// - Gain B is 9 bits: msb control bit 1, low byte at 25H.
`ifndef REGBANK_MAP_SVH
`define REGBANK_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_STATUS_ONE 8'h1E
`define REG_STATUS_TWO 8'h1F
`define REG_CTRL_A 8'h23
`define REG_GAIN_LOW_A 8'h24
`define REG_GAIN_LOW_B 8'h25

// ----------------------------------------
// Field positions
// ----------------------------------------
`define S1_HLOCK_BIT 6
`define S1_SLOW_BIT 5
`define S1_TOP_BIT 4
`define S1_BOTTOM_BIT 3
`define S1_WPEAK_BIT 2
`define S2_INTERLACE_FLAG_BIT 7
`define S2_HVUNL_BIT 6
`define S2_FIELD_BIT 5
`define S2_UNDEF_BIT 4
`define S2_FOUR_BIT 3
`define S2_ANY_BIT 2
`define S2_COPY_PROTECT_FLAG_BIT 1
`define S2_READY_BIT 0
`define CA_DRIVE_BIT 6
`define CA_CLKSEL_BIT 5

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CTRL_A_RESET 8'h00
`define CTRL_A_WMASK 8'hF7
`define GAIN_LOW_RESET 8'h90
`define CSTD_BW 2'h0
`define CSTD_NTSC 2'h1
`define CSTD_PAL 2'h2
`define CSTD_SECAM 2'h3

`endif

/* File: regbank_pkg.sv */
package regbank_pkg;

    // Raw loop status as it leaves the decoder loops
    typedef struct packed {
        logic interlaced;
        logic horiz_unlocked;
        logic vert_unlocked;
        logic slow_tc;
        logic gain_top;
        logic gain_bottom;
        logic white_peak;
        logic [1:0] colour_std;
        logic field_60;
        logic stripe_four;
        logic stripe_any;
        logic copy_protect;
        logic loops_locked;
    } status_in_t;

    typedef struct packed {
        logic undef7;
        logic horiz_unlocked_flag;
        logic slow_time_const_flag;
        logic luma_gain_top_limit_flag;
        logic luma_gain_bottom_limit_flag;
        logic white_peak_active_flag;
        logic [1:0] colour_standard_code;
    } status_one_t;

    typedef struct packed {
        logic interlace_flag;
        logic hv_loops_unlocked_flag;
        logic field_rate_flag;
        logic undef4;
        logic stripe_burst_four_line_flag;
        logic stripe_burst_any_flag;
        logic copy_protect_flag;
        logic capture_ready_flag;
    } status_two_t;

    typedef struct packed {
        logic analog_out_select_bit;
        logic adc_port_drive_enable;
        logic adc_clock_source_select;
        logic clamp_or_reference_select;
        logic undef3;
        logic source_switch_input_enable;
        logic gain_b_msb;
        logic gain_a_msb;
    } ctrl_a_t;

endpackage

/* File: status_sampler.sv */
`timescale 1ns/100ps
module status_sampler
    import regbank_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Loop status from the decoder clock domain
    input status_in_t raw_status,
    // Coherent snapshot
    output status_in_t snap_q
);

    status_in_t s1_q;
    status_in_t s2_q;
    status_in_t s3_q;

    // ----------------------------------------
    // Three-stage capture
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= raw_status;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // coherent snapshot
    // Whole word moves only when every bit has settled, never half-old
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            snap_q <= '0;
        else if (s2_q == s3_q)
            snap_q <= s3_q;
    end

    snap_settled_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$stable(snap_q) |-> $past(s2_q) == $past(s3_q)
            && snap_q == $past(s3_q))
    else $error("snapshot moved while status unsettled");

endmodule

/* File: source_switch_edge.sv */
`timescale 1ns/100ps
module source_switch_edge
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pin and control
    input wire logic source_switch_input_pin,
    input wire logic source_switch_input_enable,
    // Gain loop reset pulse
    output logic gain_loop_reset
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic primed_q;
    logic [1:0] fill_q;
    logic change;

    // ----------------------------------------
    // Pin capture
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= source_switch_input_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign change = (s2_q == s3_q) && (s3_q != level_q) && primed_q;

    // Stages hold real pin samples only three edges after reset;
    // learning earlier would turn a pin idling high into an edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            fill_q <= 2'h0;
        else if (fill_q != 2'h3)
            fill_q <= fill_q + 2'h1;
    end

    // First settled level after reset is learned, not taken as an edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            level_q <= 1'b0;
            primed_q <= 1'b0;
        end
        else if (fill_q == 2'h3 && s2_q == s3_q)
        begin
            level_q <= s3_q;
            primed_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            gain_loop_reset <= 1'b0;
        else
            gain_loop_reset <= change && source_switch_input_enable;
    end

    edge_gated_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        gain_loop_reset |-> $past(source_switch_input_enable)
            && $past(s3_q) != $past(level_q))
    else $error("gain loop reset without enabled edge");

endmodule

/* File: status_regbank.sv */
`timescale 1ns/100ps
`include "regbank_map.svh"
module status_regbank
    import regbank_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port behind the serial control bus
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    // Decoder loop status
    input status_in_t loop_status,
    // Clamp setting held elsewhere
    input wire logic clamp_setting_bit,
    // Source switch indicator pin
    input wire logic source_switch_input_pin,
    // Analog input control outputs
    output logic analog_out_select_bit,
    output logic adc_port_drive_enable,
    output logic ad_port_oe,
    output logic adc_clock_source_select,
    output logic clamp_or_reference_select,
    output logic adc_clamp_enable,
    output logic source_switch_input_enable,
    output logic gain_loop_reset,
    output logic [8:0] gain_a,
    output logic [8:0] gain_b
);

    ctrl_a_t ctrl_a_q;
    logic [7:0] gain_a_low_bits_q;
    logic [7:0] gain_b_low_bits_q;
    logic clamp_q;
    logic [7:0] rdata_q;
    logic ack_q;
    logic [7:0] rdata_d;
    status_in_t snap;
    status_one_t status_one;
    status_two_t status_two;
    logic rd_one;
    logic rd_two;

    function automatic logic hit(input logic [7:0] addr,
        input logic [7:0] offset);
        return addr == offset;
    endfunction

    // ----------------------------------------
    // Status capture
    // ----------------------------------------
    status_sampler u_sampler
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw_status(loop_status),
        .snap_q(snap)
    );

    // ----------------------------------------
    // Status byte composition
    // ----------------------------------------
    always_comb
    begin
        status_one.undef7 = 1'b0;
        status_one.horiz_unlocked_flag = snap.horiz_unlocked;
        status_one.slow_time_const_flag = snap.slow_tc;
        status_one.luma_gain_top_limit_flag = snap.gain_top;
        status_one.luma_gain_bottom_limit_flag = snap.gain_bottom;
        status_one.white_peak_active_flag = snap.white_peak;
        status_one.colour_standard_code = snap.colour_std;
    end

    always_comb
    begin
        status_two.interlace_flag = snap.interlaced;
        status_two.hv_loops_unlocked_flag =
            snap.horiz_unlocked | snap.vert_unlocked;
        status_two.field_rate_flag = snap.field_60;
        status_two.undef4 = 1'b0;
        status_two.stripe_burst_four_line_flag = snap.stripe_four;
        status_two.stripe_burst_any_flag = snap.stripe_any;
        status_two.copy_protect_flag = snap.copy_protect;
        // capture ready
        // Ready is forced low whenever either sync loop reports unlock
        status_two.capture_ready_flag = snap.loops_locked
            & ~snap.horiz_unlocked & ~snap.vert_unlocked;
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // status ignores writes
    // Only control offsets decode for writes; status has no storage
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ctrl_a_q <= ctrl_a_t'(`CTRL_A_RESET);
        else if (reg_wr && hit(reg_addr, `REG_CTRL_A))
            ctrl_a_q <= ctrl_a_t'(reg_wdata & `CTRL_A_WMASK);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            gain_a_low_bits_q <= `GAIN_LOW_RESET;
        else if (reg_wr && hit(reg_addr, `REG_GAIN_LOW_A))
            gain_a_low_bits_q <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            gain_b_low_bits_q <= `GAIN_LOW_RESET;
        else if (reg_wr && hit(reg_addr, `REG_GAIN_LOW_B))
            gain_b_low_bits_q <= reg_wdata;
    end

    // clamp or reference
    // Registered so the clamp line stays a flop output
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            clamp_q <= 1'b0;
        else
            clamp_q <= ~ctrl_a_q.clamp_or_reference_select
                & clamp_setting_bit;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        case (reg_addr)
            `REG_STATUS_ONE: rdata_d = status_one;
            `REG_STATUS_TWO: rdata_d = status_two;
            `REG_CTRL_A: rdata_d = ctrl_a_q;
            `REG_GAIN_LOW_A: rdata_d = gain_a_low_bits_q;
            `REG_GAIN_LOW_B: rdata_d = gain_b_low_bits_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rdata_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else
            ack_q <= reg_rd | reg_wr;
    end

    // ----------------------------------------
    // Source switch edge
    // ----------------------------------------
    source_switch_edge u_edge
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .source_switch_input_pin(source_switch_input_pin),
        .source_switch_input_enable(ctrl_a_q.source_switch_input_enable),
        .gain_loop_reset(gain_loop_reset)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;
    assign analog_out_select_bit = ctrl_a_q.analog_out_select_bit;
    assign adc_port_drive_enable = ctrl_a_q.adc_port_drive_enable;
    assign ad_port_oe = ctrl_a_q.adc_port_drive_enable;
    assign adc_clock_source_select = ctrl_a_q.adc_clock_source_select;
    assign clamp_or_reference_select = ctrl_a_q.clamp_or_reference_select;
    assign adc_clamp_enable = clamp_q;
    assign source_switch_input_enable = ctrl_a_q.source_switch_input_enable;
    assign gain_a = {ctrl_a_q.gain_a_msb, gain_a_low_bits_q};
    assign gain_b = {ctrl_a_q.gain_b_msb, gain_b_low_bits_q};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    assign rd_one = reg_rd && hit(reg_addr, `REG_STATUS_ONE);
    assign rd_two = reg_rd && hit(reg_addr, `REG_STATUS_TWO);

    hlock_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_one |=> reg_rdata[`S1_HLOCK_BIT] == $past(snap.horiz_unlocked))
    else $error("horizontal lock bit wrong");

    slow_tc_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_one |=> reg_rdata[`S1_SLOW_BIT] == $past(snap.slow_tc))
    else $error("slow time constant bit wrong");

    gain_limit_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_one |=> reg_rdata[`S1_TOP_BIT] == $past(snap.gain_top)
            && reg_rdata[`S1_BOTTOM_BIT] == $past(snap.gain_bottom))
    else $error("gain limit bits wrong");

    white_peak_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_one |=> reg_rdata[`S1_WPEAK_BIT] == $past(snap.white_peak))
    else $error("white peak bit wrong");

    colour_std_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_one |=> reg_rdata[1:0] == $past(snap.colour_std))
    else $error("colour standard code wrong");

    status_write_ignored_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && (hit(reg_addr, `REG_STATUS_ONE)
            || hit(reg_addr, `REG_STATUS_TWO))
            |=> $stable(ctrl_a_q) && $stable(gain_a_low_bits_q)
            && $stable(gain_b_low_bits_q))
    else $error("status write changed a register");

    undef_zero_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_one |=> !reg_rdata[7]) and (rd_two |=> !reg_rdata[4]))
    else $error("undefined status bit not zero");

    interlace_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two |=> reg_rdata[`S2_INTERLACE_FLAG_BIT] == $past(snap.interlaced))
    else $error("interlace bit wrong");

    hv_unlock_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two |=> reg_rdata[`S2_HVUNL_BIT] == ($past(snap.horiz_unlocked)
            | $past(snap.vert_unlocked)))
    else $error("loop unlock bit wrong");

    capture_ready_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two ##1 reg_rdata[`S2_READY_BIT]
            |-> !reg_rdata[`S2_HVUNL_BIT])
    else $error("capture ready while loops unlocked");

    gain_a_write_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && hit(reg_addr, `REG_GAIN_LOW_A)
            |=> gain_a[7:0] == $past(reg_wdata))
    else $error("gain A low byte not stored");

    clamp_follow_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 adc_clamp_enable |-> $past(clamp_setting_bit)
            && !$past(clamp_or_reference_select))
    else $error("clamp active in reference mode");

    field_rate_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two |=> reg_rdata[`S2_FIELD_BIT] == $past(snap.field_60))
    else $error("field rate bit wrong");

    four_line_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two |=> reg_rdata[`S2_FOUR_BIT] == $past(snap.stripe_four))
    else $error("four-line burst bit wrong");

    any_burst_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two |=> reg_rdata[`S2_ANY_BIT] == $past(snap.stripe_any))
    else $error("stripe burst bit wrong");

    copy_protect_read_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_two |=> reg_rdata[`S2_COPY_PROTECT_FLAG_BIT] == $past(snap.copy_protect))
    else $error("copy protection bit wrong");

    port_drive_write_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && hit(reg_addr, `REG_CTRL_A)
            |=> ad_port_oe == $past(reg_wdata[`CA_DRIVE_BIT]))
    else $error("AD port drive not set by write");

    clock_select_write_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && hit(reg_addr, `REG_CTRL_A)
            |=> adc_clock_source_select == $past(reg_wdata[`CA_CLKSEL_BIT]))
    else $error("ADC clock select not set by write");

    gain_b_write_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && hit(reg_addr, `REG_GAIN_LOW_B)
            |=> gain_b[7:0] == $past(reg_wdata))
    else $error("gain B low byte not stored");

endmodule

/* File: host_model.sv */
`timescale 1ns/100ps
module host_model
(
    // Clock
    input wire logic ref_clk,
    // Register port toward the bank
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    logic ack_seen;

    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        ack_seen = 1'b0;
    end

    // ----------------------------------------
    // One access: one-cycle request, answer one edge later
    // ----------------------------------------
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge ref_clk);
        reg_wr = wr;
        reg_rd = ~wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        ack_seen = reg_ack;
        q = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released lines must not keep showing the last value
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

/* File: tb_status_regbank.sv */
`timescale 1ns/100ps
module tb_status_regbank
    import regbank_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_ack;
    status_in_t loop_status = '0;
    logic clamp_setting_bit = 1'b0;
    logic source_switch_input_pin = 1'b0;
    logic analog_out_select_bit, adc_port_drive_enable, ad_port_oe;
    logic adc_clock_source_select, clamp_or_reference_select;
    logic adc_clamp_enable, source_switch_input_enable, gain_loop_reset;
    logic [8:0] gain_a, gain_b;
    int fails = 0;
    int num_checks = 0;

    always #5 ref_clk = ~ref_clk;

    host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack));

    status_regbank DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .loop_status(loop_status), .clamp_setting_bit(clamp_setting_bit),
        .source_switch_input_pin(source_switch_input_pin),
        .analog_out_select_bit(analog_out_select_bit),
        .adc_port_drive_enable(adc_port_drive_enable),
        .ad_port_oe(ad_port_oe),
        .adc_clock_source_select(adc_clock_source_select),
        .clamp_or_reference_select(clamp_or_reference_select),
        .adc_clamp_enable(adc_clamp_enable),
        .source_switch_input_enable(source_switch_input_enable),
        .gain_loop_reset(gain_loop_reset), .gain_a(gain_a),
        .gain_b(gain_b));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b1, a, d, q);
        chk({8'h00, host.ack_seen}, 9'h001);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.access(1'b0, a, 8'h00, q);
        chk({8'h00, host.ack_seen}, 9'h001);
        chk({1'b0, q}, {1'b0, exp});
    endtask

    function automatic logic [7:0] exp_one(status_in_t s);
        return {1'b0, s.horiz_unlocked, s.slow_tc, s.gain_top,
                s.gain_bottom, s.white_peak, s.colour_std};
    endfunction

    function automatic logic [7:0] exp_two(status_in_t s);
        return {s.interlaced, s.horiz_unlocked | s.vert_unlocked,
                s.field_60, 1'b0, s.stripe_four, s.stripe_any,
                s.copy_protect,
                s.loops_locked & ~s.horiz_unlocked & ~s.vert_unlocked};
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(gain_a, 9'h090);
        chk(gain_b, 9'h090);
        chk({8'h00, ad_port_oe}, 9'h000);
        rd_chk(8'h23, 8'h00);
        rd_chk(8'h24, 8'h90);
        rd_chk(8'h25, 8'h90);
    endtask

    // Each status input alone, then all set and all clear
    task automatic t_status();
        status_in_t s;
        for (int i = 0; i < 16; i++)
        begin
            s = (i < 14) ? status_in_t'(14'h0001 << i) : '0;
            if (i == 14)
                s = '1;
            @(negedge ref_clk);
            loop_status = s;
            repeat (8) @(negedge ref_clk);
            rd_chk(8'h1E, exp_one(s));
            rd_chk(8'h1F, exp_two(s));
        end
    endtask

    // Host writes to status bytes are ignored
    task automatic t_status_ro();
        status_in_t s;
        s = status_in_t'(14'h2A5B);
        @(negedge ref_clk);
        loop_status = s;
        repeat (8) @(negedge ref_clk);
        wr(8'h1E, 8'hFF);
        wr(8'h1F, ~exp_two(s));
        rd_chk(8'h1E, exp_one(s));
        rd_chk(8'h1F, exp_two(s));
    endtask

    task automatic t_ctrl();
        clamp_setting_bit = 1'b1;
        wr(8'h23, 8'hFF);
        rd_chk(8'h23, 8'hF7);
        chk({7'h00, adc_port_drive_enable, ad_port_oe}, 9'h003);
        chk({8'h00, adc_clock_source_select}, 9'h001);
        chk({7'h00, clamp_or_reference_select, adc_clamp_enable},
            9'h002);
        chk({7'h00, analog_out_select_bit, source_switch_input_enable},
            9'h003);
        wr(8'h23, 8'h00);
        @(negedge ref_clk);
        chk({7'h00, adc_port_drive_enable, ad_port_oe}, 9'h000);
        chk({8'h00, adc_clock_source_select}, 9'h000);
        chk({7'h00, clamp_or_reference_select, adc_clamp_enable},
            9'h001);
    endtask

    // Gains at their extremes, plus an unmapped place
    task automatic t_gain();
        wr(8'h24, 8'hFF);
        wr(8'h25, 8'h00);
        wr(8'h23, 8'h01);
        chk(gain_a, 9'h1FF);
        chk(gain_b, 9'h000);
        wr(8'h23, 8'h02);
        wr(8'h25, 8'h91);
        chk(gain_a, 9'h0FF);
        chk(gain_b, 9'h191);
        wr(8'h30, 8'hA5);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h24, 8'hFF);
        rd_chk(8'h25, 8'h91);
    endtask

    // Count gain loop reset pulses after one pin edge
    task automatic pin_edge(input logic en, input logic lvl,
                            input int exp);
        int n;
        n = 0;
        wr(8'h23, {5'h00, en, 2'h0});
        repeat (10) @(negedge ref_clk);
        source_switch_input_pin = lvl;
        repeat (12)
        begin
            @(negedge ref_clk);
            if (gain_loop_reset === 1'b1)
                n++;
        end
        chk(n[8:0], exp[8:0]);
    endtask

    task automatic t_switch();
        pin_edge(1'b1, 1'b1, 1);
        pin_edge(1'b1, 1'b0, 1);
        pin_edge(1'b0, 1'b1, 0);
        pin_edge(1'b0, 1'b0, 0);
    endtask

    // Reset again with the pin idling high: no false edge may follow
    task automatic t_rst_high();
        int n;
        n = 0;
        source_switch_input_pin = 1'b1;
        rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        chk(gain_a, 9'h090);
        chk(gain_b, 9'h090);
        wr(8'h23, 8'h04);
        repeat (12)
        begin
            @(negedge ref_clk);
            if (gain_loop_reset === 1'b1)
                n++;
        end
        chk(n[8:0], 9'h000);
        pin_edge(1'b1, 1'b0, 1);
    endtask

    // ----------------------------------------
    // Verdict
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    initial
    begin
        #200000;
        fails++;
        results();
    end

    initial
    begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_status();
        t_status_ro();
        t_ctrl();
        t_gain();
        t_switch();
        t_rst_high();
        results();
    end
endmodule
